// ### src/rwbc_map.svh
`ifndef RWBC_MAP_SVH
`define RWBC_MAP_SVH

`define RWBC_ADDR_W 4
`define RWBC_OFS_ATTR_MAIN 4'h0
`define RWBC_OFS_ATTR_SECOND 4'h1
`define RWBC_OFS_BASE 4'h2
`define RWBC_OFS_REGION 4'h3
`define RWBC_OFS_IRQ_FLAGS 4'h4
`define RWBC_OFS_IRQ_MASK 4'h5
`define RWBC_OFS_PORT_FLAGS 4'h6
`define RWBC_OFS_STATUS 4'h7
`define RWBC_OFS_FRAME_CNT 4'h8

`define RWBC_BIT_ENABLE 0
`define RWBC_BIT_REGION 0
`define RWBC_BIT_PORT_VSYNC 1
`define RWBC_BIT_WB_SYNC 4
`define RWBC_BIT_REGION_DONE 5

`define RWBC_RST_WORD 32'h0000_0000
`define RWBC_CNT_W 16

`endif

// ### src/rwbc_pkg.sv
package rwbc_pkg;
	typedef enum logic [1:0] {
		RWBC_IDLE = 2'b00,
		RWBC_FULL = 2'b01,
		RWBC_REGION = 2'b11,
		RWBC_DONE = 2'b10
	} rwbc_phase_t;

	typedef struct packed {
		logic [31:0] base;
		logic [31:0] region;
	} rwbc_cfg_t;
endpackage

// ### src/rwbc_cfg_if.sv
`timescale 1ns/1ps
interface rwbc_cfg_if;
	logic frame_start;
	logic region_sel;
	rwbc_pkg::rwbc_cfg_t shadow;
	rwbc_pkg::rwbc_cfg_t active;
	logic active_region;
	modport ctl (output frame_start, output region_sel, output shadow,
		input active, input active_region);
	modport lat (input frame_start, input region_sel, input shadow,
		output active, output active_region);
endinterface

// ### src/rwbc_latch.sv
`timescale 1ns/1ps
module rwbc_latch (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_hold,
	rwbc_cfg_if.lat cfg
);
	typedef struct packed {
		rwbc_pkg::rwbc_cfg_t active;
		logic region;
		logic region_d;
	} rwbc_latch_st_t;

	rwbc_latch_st_t st;
	rwbc_latch_st_t next_st;

	always_comb begin
		next_st = st;
		if (cfg.frame_start) begin
			if (!i_hold) begin
				next_st.active = cfg.shadow;
			end
			next_st.region_d = cfg.region_sel;
			next_st.region = st.region_d;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign cfg.active = st.active;
	assign cfg.active_region = st.region;
endmodule

// ### src/rwbc_top.sv
`timescale 1ns/1ps
`include "rwbc_map.svh"
module rwbc_top (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic [`RWBC_ADDR_W-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	input wire logic i_frame_start,
	input wire logic i_region_end,
	input wire logic i_frame_end,
	input wire logic i_port_vsync,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	output logic o_irq,
	output logic o_wb_active,
	output logic o_wb_region_mode,
	output logic [31:0] o_wb_base,
	output logic [31:0] o_wb_region
);
	typedef struct packed {
		// Two sync stages, third feeds edge detect
		logic [2:0] fs_sync;
		logic [2:0] re_sync;
		logic [2:0] fe_sync;
		logic [2:0] pv_sync;
		logic enable;
		logic region_sel;
		rwbc_pkg::rwbc_cfg_t shadow;
		logic shadow_late;
		logic [5:0] flags;
		logic [5:0] mask;
		rwbc_pkg::rwbc_phase_t phase;
		logic [`RWBC_CNT_W-1:0] frames;
		logic ack;
		logic [31:0] rdata;
		logic irq;
		logic region_mode;
		logic fs_d;
		logic wait_req;
		logic wb_active;
	} rwbc_st_t;

	rwbc_st_t st;
	rwbc_st_t next_st;
	rwbc_cfg_if cfg ();

	function automatic logic [31:0] rwbc_merge(input logic [31:0] old,
			input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic rise(input logic [2:0] s);
		return s[1] & ~s[2];
	endfunction

	// Frame data is flowing in these phases
	function automatic logic rwbc_writing(
			input rwbc_pkg::rwbc_phase_t p);
		return p == rwbc_pkg::RWBC_FULL || p == rwbc_pkg::RWBC_REGION;
	endfunction

	logic fs;
	logic re;
	logic fe;
	logic pv;
	logic acc;
	logic wr;
	logic rd;
	logic [5:0] ev;
	logic [31:0] wdm;

	always_comb begin
		fs = rise(st.fs_sync) & st.enable;
		re = rise(st.re_sync) & st.enable & cfg.active_region;
		fe = rise(st.fe_sync) & st.enable;
		pv = rise(st.pv_sync);
		acc = (i_avs_read | i_avs_write) & ~st.ack;
		wr = i_avs_write & acc;
		rd = i_avs_read & acc;
		wdm = '0;
		ev = '0;
		ev[`RWBC_BIT_PORT_VSYNC] = pv;
		ev[`RWBC_BIT_WB_SYNC] = fs;
		ev[`RWBC_BIT_REGION_DONE] = re;
		next_st = st;
		next_st.fs_sync = {st.fs_sync[1:0], i_frame_start};
		next_st.re_sync = {st.re_sync[1:0], i_region_end};
		next_st.fe_sync = {st.fe_sync[1:0], i_frame_end};
		next_st.pv_sync = {st.pv_sync[1:0], i_port_vsync};
		next_st.ack = acc;
		next_st.wait_req = ~acc;
		// Latch updates on fs; mode reads it one cycle on
		next_st.fs_d = fs;
		next_st.rdata = '0;
		if (fs) begin
			next_st.frames = st.frames + 1'b1;
			next_st.shadow_late = 1'b0;
		end
		// mode from the select latched one frame start earlier
		if (st.fs_d) begin
			next_st.region_mode = cfg.active_region;
			next_st.phase = cfg.active_region ? rwbc_pkg::RWBC_REGION
				: rwbc_pkg::RWBC_FULL;
		end else if (re && st.phase == rwbc_pkg::RWBC_REGION) begin
			next_st.phase = rwbc_pkg::RWBC_DONE;
		end else if (fe) begin
			next_st.phase = rwbc_pkg::RWBC_IDLE;
		end
		if (!st.enable) begin
			next_st.phase = rwbc_pkg::RWBC_IDLE;
		end
		next_st.wb_active = rwbc_writing(next_st.phase);
		// Writes commit on the accepted cycle
		if (wr) begin
			case (i_avs_address)
				`RWBC_OFS_ATTR_MAIN: begin
					wdm = rwbc_merge({31'h0, st.enable}, i_avs_writedata,
						i_avs_byteenable);
					next_st.enable = wdm[`RWBC_BIT_ENABLE];
				end
				`RWBC_OFS_ATTR_SECOND: begin
					wdm = rwbc_merge({31'h0, st.region_sel}, i_avs_writedata,
						i_avs_byteenable);
					next_st.region_sel = wdm[`RWBC_BIT_REGION];
				end
				`RWBC_OFS_BASE: begin
					next_st.shadow.base = rwbc_merge(st.shadow.base,
						i_avs_writedata, i_avs_byteenable);
					next_st.shadow_late = st.flags[`RWBC_BIT_WB_SYNC];
				end
				`RWBC_OFS_REGION: begin
					next_st.shadow.region = rwbc_merge(st.shadow.region,
						i_avs_writedata, i_avs_byteenable);
					next_st.shadow_late = st.flags[`RWBC_BIT_WB_SYNC];
				end
				`RWBC_OFS_IRQ_MASK: begin
					wdm = rwbc_merge({26'h0, st.mask}, i_avs_writedata,
						i_avs_byteenable);
					next_st.mask = wdm[5:0];
				end
				default: begin
					next_st.mask = st.mask;
				end
			endcase
		end
		if (rd) begin
			case (i_avs_address)
				`RWBC_OFS_ATTR_MAIN: next_st.rdata = {31'h0, st.enable};
				`RWBC_OFS_ATTR_SECOND: next_st.rdata = {31'h0, st.region_sel};
				`RWBC_OFS_BASE: next_st.rdata = st.shadow.base;
				`RWBC_OFS_REGION: next_st.rdata = st.shadow.region;
				`RWBC_OFS_IRQ_FLAGS: next_st.rdata = {26'h0, st.flags};
				`RWBC_OFS_IRQ_MASK: next_st.rdata = {26'h0, st.mask};
				`RWBC_OFS_PORT_FLAGS: begin
					next_st.rdata = {30'h0, st.flags[`RWBC_BIT_PORT_VSYNC],
						1'b0};
				end
				`RWBC_OFS_STATUS: begin
					next_st.rdata = {27'h0, st.shadow_late, st.region_mode,
						st.phase, st.enable};
				end
				`RWBC_OFS_FRAME_CNT: begin
					next_st.rdata = {{(32-`RWBC_CNT_W){1'b0}}, st.frames};
				end
				default: next_st.rdata = `RWBC_RST_WORD;
			endcase
		end
		if (rd && i_avs_address == `RWBC_OFS_IRQ_FLAGS) begin
			next_st.flags = ev;
		end else begin
			next_st.flags = st.flags | ev;
		end
		// Level irq from the flags being stored
		next_st.irq = |(next_st.flags & next_st.mask);
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			st <= '0;
			// Bus stalls while reset is held
			st.wait_req <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign cfg.frame_start = fs;
	assign cfg.region_sel = st.region_sel;
	assign cfg.shadow = st.shadow;

	// Holds the active config, late writes kept back
	rwbc_latch u_latch (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_hold(st.shadow_late),
		.cfg(cfg)
	);

	assign o_avs_readdata = st.rdata;
	assign o_avs_waitrequest = st.wait_req;
	assign o_irq = st.irq;
	assign o_wb_active = st.wb_active;
	assign o_wb_region_mode = st.region_mode;
	assign o_wb_base = cfg.active.base;
	assign o_wb_region = cfg.active.region;
endmodule

// ### verif/rwbc_monitor.sv
`timescale 1ns/1ps
module rwbc_monitor (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic [3:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic i_frame_start,
	input wire logic o_irq,
	input wire logic o_wb_region_mode,
	input wire logic [31:0] o_wb_base,
	input wire logic [31:0] o_wb_region
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	cfg_hold_a: assert property ($changed(o_wb_base) |->
		$past(i_frame_start, 3) || $past(i_frame_start, 5))
		else $error("base moved off frame start");
	area_hold_a: assert property ($changed(o_wb_region) |->
		$past(i_frame_start, 3) || $past(i_frame_start, 5))
		else $error("region moved off frame start");
	full_frame_a: assert property ($fell(o_wb_region_mode) |->
		$past(i_frame_start, 3) || $past(i_frame_start, 5))
		else $error("mode left region off frame start");
	mode_resume_a: assert property ($rose(o_wb_region_mode) |->
		$past(i_frame_start, 3) || $past(i_frame_start, 5))
		else $error("mode entered region off frame start");
	flag_stick_a: assert property ($fell(o_irq) |->
		$past(i_avs_read || i_avs_write) && $past(i_avs_address) >= 4'h4)
		else $error("irq dropped without clear");
endmodule
bind rwbc_top rwbc_monitor u_rwbc_monitor (.i_clk_sys(i_clk_sys),
	.i_rst(i_rst), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
	.i_avs_write(i_avs_write), .i_frame_start(i_frame_start), .o_irq(o_irq),
	.o_wb_region_mode(o_wb_region_mode), .o_wb_base(o_wb_base),
	.o_wb_region(o_wb_region));

// ### verif/rwbc_fb_model.sv
`timescale 1ns/1ps
module rwbc_fb_model (
	input wire logic i_clk_sys,
	input wire logic i_wb_active,
	output logic [3:0] o_events,
	output logic [15:0] o_words
);
	initial o_events = 4'h0;
	initial o_words = 16'h0;
	// counts words while wb is active, cleared on frame start
	always @(posedge i_clk_sys) begin
		if (o_events[0])
			o_words <= 16'h0;
		else if (i_wb_active)
			o_words <= o_words + 16'h1;
	end
	task step(input logic [3:0] e);
		o_events <= e;
		repeat (6) @(posedge i_clk_sys);
		o_events <= 4'h0;
		repeat (20) @(posedge i_clk_sys);
	endtask
	// start, region, end, vsync in order
	task frame();
		step(4'h1);
		step(4'h2);
		step(4'h4);
		step(4'h8);
	endtask
endmodule

// ### verif/test_region_writeback_capture.sv
`timescale 1ns/1ps
module test_region_writeback_capture;
	logic i_clk_sys = 1'b0;
	logic i_rst = 1'b1;
	logic [3:0] addr = 4'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdat, base, area, q;
	logic wait_r, irq, act, mode;
	logic [3:0] ev;
	logic [15:0] words, words_full;
	int n_fail = 0;
	int comparisons = 0;
	int cyc = 0;
	always #4 i_clk_sys = ~i_clk_sys;
	rwbc_top u_rwbc_top (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
		.i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
		.i_avs_writedata(wd), .i_avs_byteenable(4'hf),
		.i_frame_start(ev[0]), .i_region_end(ev[1]), .i_frame_end(ev[2]),
		.i_port_vsync(ev[3]), .o_avs_readdata(rdat),
		.o_avs_waitrequest(wait_r), .o_irq(irq), .o_wb_active(act),
		.o_wb_region_mode(mode), .o_wb_base(base), .o_wb_region(area));
	rwbc_fb_model u_rwbc_fb_model (.i_clk_sys(i_clk_sys),
		.i_wb_active(act), .o_events(ev), .o_words(words));
	task finish_test();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge i_clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			finish_test();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge i_clk_sys);
		addr <= a;
		wd <= d;
		rd <= !w;
		wr <= w;
		do @(posedge i_clk_sys); while (wait_r !== 1'b0);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task t_regs();
		bus(0, 4'h4, 32'h0);
		chk(q, 32'h0);
		bus(0, 4'h9, 32'h0);
		chk(q, 32'h0);
		bus(1, 4'h2, 32'h0000_1000);
		bus(0, 4'h2, 32'h0);
		chk(q, 32'h0000_1000);
		$display("t_regs done");
	endtask
	task t_mode();
		bus(1, 4'h0, 32'h1);
		bus(1, 4'h1, 32'h1);
		u_rwbc_fb_model.frame();
		words_full = words;
		chk({31'h0, mode}, 32'h0);
		chk(base, 32'h0000_1000);
		u_rwbc_fb_model.frame();
		chk({31'h0, mode}, 32'h1);
		chk({31'h0, words < words_full}, 32'h1);
		bus(1, 4'h1, 32'h0);
		u_rwbc_fb_model.frame();
		chk({31'h0, mode}, 32'h1);
		u_rwbc_fb_model.frame();
		chk({31'h0, mode}, 32'h0);
		chk({16'h0, words}, {16'h0, words_full});
		$display("t_mode done");
	endtask
	task t_irq();
		bus(0, 4'h4, 32'h0);
		bus(1, 4'h5, 32'h32);
		repeat (3) @(posedge i_clk_sys);
		chk({31'h0, irq}, 32'h0);
		u_rwbc_fb_model.frame();
		chk({31'h0, irq}, 32'h1);
		bus(0, 4'h4, 32'h0);
		chk(q, 32'h12);
		repeat (3) @(posedge i_clk_sys);
		chk({31'h0, irq}, 32'h0);
		$display("t_irq done");
	endtask
	task t_recover();
		bus(1, 4'h1, 32'h1);
		u_rwbc_fb_model.frame();
		u_rwbc_fb_model.frame();
		chk({31'h0, mode}, 32'h1);
		bus(0, 4'h4, 32'h0);
		u_rwbc_fb_model.step(4'h1);
		u_rwbc_fb_model.step(4'h2);
		bus(0, 4'h4, 32'h0);
		chk(q, 32'h30);
		bus(1, 4'h1, 32'h0);
		u_rwbc_fb_model.step(4'h4);
		u_rwbc_fb_model.step(4'h8);
		u_rwbc_fb_model.frame();
		chk({31'h0, mode}, 32'h1);
		bus(1, 4'h1, 32'h1);
		bus(0, 4'h4, 32'h0);
		u_rwbc_fb_model.frame();
		chk({31'h0, mode}, 32'h0);
		bus(0, 4'h4, 32'h0);
		chk(q, 32'h12);
		u_rwbc_fb_model.frame();
		chk({31'h0, mode}, 32'h1);
		$display("t_recover done");
	endtask
	task t_cfg();
		bus(0, 4'h4, 32'h0);
		bus(0, 4'h4, 32'h0);
		chk(q, 32'h0);
		bus(1, 4'h2, 32'h0000_3000);
		bus(1, 4'h3, 32'h0040_0020);
		u_rwbc_fb_model.frame();
		chk(base, 32'h0000_3000);
		chk(area, 32'h0040_0020);
		u_rwbc_fb_model.step(4'h1);
		bus(1, 4'h2, 32'h0000_2000);
		u_rwbc_fb_model.step(4'h2);
		u_rwbc_fb_model.step(4'h4);
		u_rwbc_fb_model.step(4'h8);
		u_rwbc_fb_model.frame();
		chk(base, 32'h0000_3000);
		u_rwbc_fb_model.frame();
		chk(base, 32'h0000_2000);
		$display("t_cfg done");
	endtask
	task t_off();
		logic [31:0] n0;
		bus(1, 4'h1, 32'h0);
		u_rwbc_fb_model.frame();
		u_rwbc_fb_model.step(4'h1);
		chk({31'h0, act}, 32'h1);
		u_rwbc_fb_model.step(4'h2);
		u_rwbc_fb_model.step(4'h4);
		u_rwbc_fb_model.step(4'h8);
		bus(1, 4'h0, 32'h0);
		bus(0, 4'h8, 32'h0);
		n0 = q;
		u_rwbc_fb_model.step(4'h1);
		chk({31'h0, act}, 32'h0);
		u_rwbc_fb_model.step(4'h2);
		u_rwbc_fb_model.step(4'h4);
		u_rwbc_fb_model.step(4'h8);
		bus(0, 4'h8, 32'h0);
		chk(q, n0);
		$display("t_off done");
	endtask
	initial begin
		repeat (3) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		t_regs();
		t_mode();
		t_irq();
		t_recover();
		t_cfg();
		t_off();
		finish_test();
	end
endmodule
